// [hdl/oc_channel.sv]
// One channel of overcurrent protection and diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "oc_diag_map.svh"
module oc_channel (
   input wire logic clk,
   input wire logic rst,
   input wire oc_diag_pkg::chan_cfg_t cfg,
   input wire logic boost_sel,
   input wire logic ctrl,
   input wire logic cmp,
   input wire logic diag_read,
   input wire logic offdiag_ok,
   output logic drive_on,
   output logic [1:0] gate_cur,
   output logic [2:0] code,
   output logic [5:0] thr
);
   localparam logic [15:0] DG = 16'(`DEGLITCH_CYC);
   localparam logic [15:0] DT = 16'(`DETECT_CYC);
   oc_diag_pkg::chan_state_t st_q, st_d;
   logic [15:0] bl_q, bl_d, fl_q, fl_d;
   logic [2:0] code_q, code_d;
   logic ctrl_q, read_seen_q, read_seen_d, boost_q, boost_d, once_q, once_d;
   logic flt_blank_q, flt_blank_d;
   logic [15:0] blank_cyc;
   logic rise, oc_now, need_read;
   always_comb begin
      unique case (cfg.blanking_time_select)
         3'h0: blank_cyc = 16'(`BLANK_NS_0 * `CLK_MHZ / 1000);
         3'h1: blank_cyc = 16'(`BLANK_NS_1 * `CLK_MHZ / 1000);
         3'h2: blank_cyc = 16'(`BLANK_NS_2 * `CLK_MHZ / 1000);
         3'h3: blank_cyc = 16'(`BLANK_NS_3 * `CLK_MHZ / 1000);
         3'h4: blank_cyc = 16'(`BLANK_NS_4 * `CLK_MHZ / 1000);
         3'h5: blank_cyc = 16'(`BLANK_NS_5 * `CLK_MHZ / 1000);
         3'h6: blank_cyc = 16'(`BLANK_NS_6 * `CLK_MHZ / 1000);
         default: blank_cyc = 16'(`BLANK_NS_7 * `CLK_MHZ / 1000);
      endcase
   end
   assign rise = ctrl & ~ctrl_q;
   assign need_read = cfg.hbridge | cfg.reengage_policy_select;
   always_comb begin
      st_d = st_q;
      bl_d = bl_q;
      fl_d = fl_q;
      flt_blank_d = flt_blank_q;
      code_d = code_q;
      read_seen_d = read_seen_q | diag_read;
      boost_d = boost_q & ~diag_read;
      once_d = once_q;
      oc_now = 1'b0;
      // Remember whether the crossing began inside blanking
      if (fl_q == 16'h0000) begin
         flt_blank_d = (st_q == oc_diag_pkg::ST_BLANK) & cmp;
      end
      // Comparator filters: deglitch then detection, restarted on drop
      if (st_q == oc_diag_pkg::ST_ON || st_q == oc_diag_pkg::ST_BLANK) begin
         if (!cmp) begin
            fl_d = 16'h0000;
         end else if (fl_q < DG + DT) begin
            fl_d = fl_q + 16'h0001;
         end
         oc_now = cmp && (fl_q == DG + DT - 16'h0001);
      end else begin
         fl_d = 16'h0000;
      end
      if (diag_read) begin
         code_d = `CODE_NO_DIAG;
      end
      unique case (st_q)
         oc_diag_pkg::ST_OFF: begin
            if (ctrl) begin
               st_d = oc_diag_pkg::ST_BLANK;
               bl_d = blank_cyc;
               once_d = offdiag_ok;
            end
         end
         oc_diag_pkg::ST_BLANK: begin
            // Sense method: shunt or drain-source both stop blanking on a crossing
            if (cmp || bl_q <= 16'h0001) begin
               st_d = oc_diag_pkg::ST_ON;
            end
            bl_d = bl_q - 16'h0001;
            if (!cmp && bl_q <= 16'h0001 && code_q[2]) begin
               code_d = once_q ? `CODE_NO_FAIL : `CODE_NO_OC;
            end
            if (!ctrl) begin
               st_d = oc_diag_pkg::ST_OFF;
            end
         end
         oc_diag_pkg::ST_ON: begin
            if (code_q == `CODE_NO_FAIL && once_q) begin
               once_d = 1'b0;
            end else if (code_q[2] && !cmp) begin
               code_d = `CODE_NO_OC;
            end
            if (!ctrl) begin
               st_d = oc_diag_pkg::ST_OFF;
            end
         end
         oc_diag_pkg::ST_TRIP: begin
            if (rise && (!need_read || read_seen_q)) begin
               st_d = oc_diag_pkg::ST_BLANK;
               bl_d = blank_cyc;
               once_d = 1'b0;
            end
         end
      endcase
      if (oc_now) begin
         st_d = oc_diag_pkg::ST_TRIP;
         read_seen_d = 1'b0;
         boost_d = 1'b1;
         // Peak and hold during shunt blanking reports pin failure
         code_d = (cfg.peak_hold && cfg.sense_method_select && flt_blank_q)
                  ? `CODE_OC_PIN : `CODE_OC;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= oc_diag_pkg::ST_OFF;
         bl_q <= 16'h0000;
         fl_q <= 16'h0000;
         code_q <= `CODE_NO_DIAG;
         ctrl_q <= 1'b0;
         read_seen_q <= 1'b0;
         boost_q <= 1'b0;
         once_q <= 1'b0;
         flt_blank_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bl_q <= bl_d;
         fl_q <= fl_d;
         code_q <= code_d;
         ctrl_q <= ctrl;
         read_seen_q <= read_seen_d;
         boost_q <= boost_d;
         once_q <= once_d;
         flt_blank_q <= flt_blank_d;
      end
   end
   // Boosted shutdown current
   always_comb begin
      gate_cur = cfg.gate_current_select;
      if (boost_q && cfg.gate_current_select == `GCC_1MA) begin
         gate_cur = boost_sel ? `GCC_20MA : `GCC_5MA;
      end else if (boost_q && cfg.gate_current_select == `GCC_5MA) begin
         gate_cur = `GCC_20MA;
      end
   end
   assign drive_on = (st_q == oc_diag_pkg::ST_BLANK) || (st_q == oc_diag_pkg::ST_ON);
   assign code = code_q;
   assign thr = cfg.threshold_code;
endmodule : oc_channel
`default_nettype wire

// [hdl/oc_diag_top.sv]
// Eight-channel ON-state overcurrent protection and diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "oc_diag_map.svh"
//////////////////////////////////////////////////////////////////////
module oc_diag_top (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Configuration, per channel and shared by all channels
   input wire oc_diag_pkg::chan_cfg_t [7:0] CHAN_CFG,
   input wire logic SHUTDOWN_CURRENT_BOOST_SELECT,
   input wire logic [7:0] SERIAL_CHANNEL_ON_BIT,
   input wire logic DIAG_READ,
   input wire logic [7:0] OFFDIAG_CLEAN,
   // Pins
   input wire logic [7:0] CHANNEL_CONTROL_PIN,
   input wire logic [7:0] COMPARATOR_OUT,
   // Outputs
   output logic [7:0] GATE_ON,
   output logic [15:0] GATE_CURRENT,
   output logic [23:0] CHANNEL_FAULT_CODE,
   output logic [47:0] THRESHOLD_REF
);
   logic [7:0] pin_s1_q, pin_s2_q, cmp_s1_q, cmp_s2_q;
   logic [7:0] on_w;
   logic [15:0] cur_w;
   logic [23:0] code_w;
   logic [47:0] thr_w;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         pin_s1_q <= 8'h00;
         pin_s2_q <= 8'h00;
         cmp_s1_q <= 8'h00;
         cmp_s2_q <= 8'h00;
      end else begin
         pin_s1_q <= CHANNEL_CONTROL_PIN;
         pin_s2_q <= pin_s1_q;
         cmp_s1_q <= COMPARATOR_OUT;
         cmp_s2_q <= cmp_s1_q;
      end
   end
   //////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_ch
         oc_channel u_ch (
            .clk(CLK_SYS),
            .rst(RST),
            .cfg(CHAN_CFG[i]),
            .boost_sel(SHUTDOWN_CURRENT_BOOST_SELECT),
            // Control source choice
            .ctrl(CHAN_CFG[i].control_source_select ? SERIAL_CHANNEL_ON_BIT[i] : pin_s2_q[i]),
            .cmp(cmp_s2_q[i]),
            .diag_read(DIAG_READ),
            .offdiag_ok(OFFDIAG_CLEAN[i]),
            .drive_on(on_w[i]),
            .gate_cur(cur_w[2*i +: 2]),
            .code(code_w[3*i +: 3]),
            .thr(thr_w[6*i +: 6])
         );
      end
   endgenerate
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         GATE_ON <= 8'h00;
         GATE_CURRENT <= 16'h0000;
         CHANNEL_FAULT_CODE <= 24'hffffff;
         THRESHOLD_REF <= 48'h000000000000;
      end else begin
         GATE_ON <= on_w;
         GATE_CURRENT <= cur_w;
         CHANNEL_FAULT_CODE <= code_w;
         THRESHOLD_REF <= thr_w;
      end
   end
endmodule : oc_diag_top
`default_nettype wire

// [inc/oc_diag_map.svh]
// Timing counts, codes and field values for the overcurrent diagnostic block
`ifndef OC_DIAG_MAP_SVH
`define OC_DIAG_MAP_SVH
`define CLK_MHZ 200
// Deglitch 0.6..1 us: 0.8 us chosen
`define DEGLITCH_NS 800
`define DEGLITCH_CYC (`DEGLITCH_NS * `CLK_MHZ / 1000)
// Detection filter 2..3 us: 2.5 us chosen
`define DETECT_NS 2500
`define DETECT_CYC (`DETECT_NS * `CLK_MHZ / 1000)
// Blanking typical times in ns per code
`define BLANK_NS_0 11100
`define BLANK_NS_1 15600
`define BLANK_NS_2 20000
`define BLANK_NS_3 31100
`define BLANK_NS_4 42200
`define BLANK_NS_5 53300
`define BLANK_NS_6 97800
`define BLANK_NS_7 142200
`define CODE_OC_PIN 3'h0
`define CODE_OC 3'h1
`define CODE_NO_FAIL 3'h4
`define CODE_NO_OC 3'h5
`define CODE_NO_DIAG 3'h7
`define GCC_1MA 2'h0
`define GCC_5MA 2'h1
`define GCC_20MA 2'h3
`endif

// [inc/oc_diag_pkg.sv]
// Types shared by the overcurrent diagnostic block
package oc_diag_pkg;
   typedef struct packed {
      logic [5:0] threshold_code;
      logic [2:0] blanking_time_select;
      logic [1:0] gate_current_select;
      logic sense_method_select;
      logic reengage_policy_select;
      logic control_source_select;
      logic hbridge;
      logic peak_hold;
   } chan_cfg_t;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_BLANK = 2'b01,
      ST_ON = 2'b10,
      ST_TRIP = 2'b11
   } chan_state_t;
endpackage : oc_diag_pkg

// [verif/oc_diag_top_assertions.sv]
// Channel 0 protocol checker for the overcurrent diagnostic top
`timescale 1ns/1ps
`default_nettype none
module oc_diag_top_assertions (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   // Inputs
   input wire oc_diag_pkg::chan_cfg_t [7:0] CHAN_CFG,
   input wire logic SHUTDOWN_CURRENT_BOOST_SELECT,
   input wire logic [7:0] SERIAL_CHANNEL_ON_BIT,
   input wire logic DIAG_READ,
   input wire logic [7:0] CHANNEL_CONTROL_PIN,
   input wire logic [7:0] COMPARATOR_OUT,
   // Outputs
   input wire logic [7:0] GATE_ON,
   input wire logic [15:0] GATE_CURRENT,
   input wire logic [23:0] CHANNEL_FAULT_CODE,
   input wire logic [47:0] THRESHOLD_REF
);
   logic [9:0] hi_q;
   logic [9:0] hi_d;
   wire logic [1:0] gcs = CHAN_CFG[0].gate_current_select;
   wire logic [2:0] c0 = CHANNEL_FAULT_CODE[2:0];
   wire logic ctl = CHAN_CFG[0].control_source_select ? SERIAL_CHANNEL_ON_BIT[0] :
      CHANNEL_CONTROL_PIN[0];
   // Length of the current comparator high run, saturating
   always_comb hi_d = COMPARATOR_OUT[0] ? hi_q + 10'(hi_q != 10'h3ff) : 10'h0;
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST)
         hi_q <= 10'h0;
      else
         hi_q <= hi_d;
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   thr_copy_a: assert property (!$past(RST) |-> THRESHOLD_REF[5:0] == $past(CHAN_CFG[0].threshold_code))
      else $error("threshold not copied");
   on_lat_a: assert property ($rose(ctl) && c0[2] ##1 ctl [*5] |-> GATE_ON[0])
      else $error("gate not on");
   off_lat_a: assert property ((!ctl) [*6] |-> !GATE_ON[0])
      else $error("gate not off");
   trip_off_a: assert property ($rose(!c0[2]) |-> ##[0:2] !GATE_ON[0])
      else $error("fault without shutdown");
   filt_min_a: assert property ($fell(GATE_ON[0]) && ctl |-> hi_q >= 10'd600)
      else $error("trip too early");
   trip_bound_a: assert property (hi_q < 10'd700)
      else $error("trip too late");
   boost_current_a: assert property ($rose(!c0[2]) |-> ##1 GATE_CURRENT[1:0] ==
      (gcs == 2'h0 && !SHUTDOWN_CURRENT_BOOST_SELECT ? 2'h1 : (gcs[1] ? gcs : 2'h3)))
      else $error("shutdown current wrong");
   current_restore_a: assert property (c0 == 3'h5 && $past(c0) == 3'h5 && $stable(gcs) |->
      GATE_CURRENT[1:0] == gcs)
      else $error("gate current not restored");
   read_clr_a: assert property (DIAG_READ && !GATE_ON[0] && !COMPARATOR_OUT[0] |-> ##2 c0 == 3'h7)
      else $error("code not cleared");
   cover property ($rose(!c0[2]));
   cover property (c0 == 3'h0);
   cover property (c0 == 3'h4);
endmodule : oc_diag_top_assertions
bind oc_diag_top oc_diag_top_assertions i_chk (.CLK_SYS, .RST, .CHAN_CFG,
   .SHUTDOWN_CURRENT_BOOST_SELECT, .SERIAL_CHANNEL_ON_BIT, .DIAG_READ, .CHANNEL_CONTROL_PIN,
   .COMPARATOR_OUT, .GATE_ON, .GATE_CURRENT, .CHANNEL_FAULT_CODE, .THRESHOLD_REF);
`default_nettype wire

// [verif/oc_diag_top_tb.sv]
// Self-checking bench for the overcurrent diagnostic top
`timescale 1ns/1ps
`default_nettype none
module oc_diag_top_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   oc_diag_pkg::chan_cfg_t [7:0] cfg;
   logic boost, rd, need, ph, src;
   logic [1:0] gcs;
   logic [7:0] son, pin, ovl, clean, cmp, gon;
   logic [15:0] gcur;
   logic [23:0] code;
   logic [47:0] thr;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int w;
   oc_diag_top i_dut (.CLK_SYS(clk_sys), .RST(rst), .CHAN_CFG(cfg),
      .SHUTDOWN_CURRENT_BOOST_SELECT(boost), .SERIAL_CHANNEL_ON_BIT(son), .DIAG_READ(rd),
      .OFFDIAG_CLEAN(clean), .CHANNEL_CONTROL_PIN(pin), .COMPARATOR_OUT(cmp), .GATE_ON(gon),
      .GATE_CURRENT(gcur), .CHANNEL_FAULT_CODE(code), .THRESHOLD_REF(thr));
   oc_fet_model i_fet (.gate_on(gon), .overload(ovl), .cmp(cmp));
   initial forever #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         error_cnt++;
         final_report();
      end
   end
   task automatic final_report;
      if (error_cnt == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   task automatic check(input logic [5:0] seen, input logic [5:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick
   // Unselected source always opposes the selected one
   task automatic ctl(input logic v, input int n);
      pin[0] = src ? ~v : v;
      son[0] = src ? v : ~v;
      tick(n);
   endtask : ctl
   task automatic read_diag;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(2);
   endtask : read_diag
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {cfg, boost, rd, son, pin, ovl, clean, src} = '0;
      w = $urandom(74204);
      tick(8);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         {pin, son} = '0;
         tick(6);
         for (int c = 0; c < 8; c++)
            cfg[c] = oc_diag_pkg::chan_cfg_t'(16'($urandom));
         src = 1'($urandom);
         ph = i[0] & i[1];
         cfg[0].sense_method_select = i[0];
         cfg[0].reengage_policy_select = i[2];
         cfg[0].control_source_select = src;
         cfg[0].peak_hold = ph;
         cfg[0].blanking_time_select[2] = 1'b0;
         // Only the three defined gate currents 1, 5 and 20 mA
         cfg[0].gate_current_select[1] &= cfg[0].gate_current_select[0];
         gcs = cfg[0].gate_current_select;
         need = i[2] | cfg[0].hbridge;
         {boost, clean, pin[7:1], son[7:1]} = 23'($urandom);
         read_diag();
         check(6'(code[2:0]), 6'h07);
         ctl(1'b1, 6);
         check(6'(gon[0]), 6'h01);
         if (!i[1]) begin
            for (w = 0; code[2:0] === 3'h7 && w < 8000; w++)
               tick(1);
            check(6'(code[2:0]), clean[0] ? 6'h04 : 6'h05);
         end
         ovl[0] = 1'b1;
         for (w = 0; gon[0] === 1'b1 && w < 800; w++)
            tick(1);
         check(6'(code[2:0]), ph ? 6'h00 : 6'h01);
         check(6'(gcur[1:0]), (gcs == 2'h0 && !boost) ? 6'h01 : 6'h03);
         ovl[0] = 1'b0;
         ctl(1'b0, 8);
         ctl(1'b1, 8);
         check(6'(gon[0]), 6'(!need));
         if (need) begin
            read_diag();
            check(6'(gcur[1:0]), 6'(gcs));
            ctl(1'b0, 8);
            ctl(1'b1, 8);
            check(6'(gon[0]), 6'h01);
         end
         ctl(1'b0, 8);
         check(6'(gon[0]), 6'h00);
         check(thr[5:0], cfg[0].threshold_code);
         // Channels without overload follow their control source
         for (int c = 1; c < 8; c++) begin
            check(6'(gon[c]), 6'(cfg[c].control_source_select ? son[c] : pin[c]));
            check(6'(gcur[2*c +: 2]), 6'(cfg[c].gate_current_select));
            check(thr[6*c +: 6], cfg[c].threshold_code);
         end
      end
      final_report();
   end
endmodule : oc_diag_top_tb
`default_nettype wire

// [verif/oc_fet_model.sv]
// External FET stage model with a commanded overload
`timescale 1ns/1ps
`default_nettype none
module oc_fet_model (
   // Gate drive and overload command
   input wire logic [7:0] gate_on,
   input wire logic [7:0] overload,
   // Sense comparator result
   output logic [7:0] cmp
);
   // Sense rises above threshold only while a driven FET is overloaded
   assign cmp = gate_on & overload;
endmodule : oc_fet_model
`default_nettype wire
